// >>> logic/csw_pkg.sv
package csw_pkg;

	// ****************************************************************
	// Word layout
	// ****************************************************************
	localparam int WORD_W        = 16;
	localparam int COUNT_W       = 24;
	localparam int NUM_CH        = 2;
	localparam int CH_BITS       = 4;
	localparam int STS_UPPER_BIT = 0;
	localparam int STS_LOWER_BIT = 1;
	localparam int STS_LIMIT_BIT = 2;
	localparam int STS_GATE_BIT  = 3;
	localparam int CMD_SGATE_BIT = 0;
	localparam int CMD_OEN_BIT   = 2;
	localparam int CMD_INDIS_BIT = 3;
	localparam logic [15:0] CMD_RESET  = 16'h0000;
	localparam logic [23:0] COUNT_ZERO = 24'h00_0000;
	localparam logic [23:0] COUNT_ONE  = 24'h00_0001;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic gate;
		logic limit;
		logic pulse;
	} csw_pins_t;

	typedef struct packed {
		logic upper;
		logic lower;
	} csw_cmp_t;

endpackage : csw_pkg

// >>> logic/csw_channel.sv
`timescale 1ns/1ps

module csw_channel #(
	parameter int COUNT_W = 24
) (
	input  wire logic               core_clk,
	input  wire logic               srst,
	input  csw_pkg::csw_pins_t      pins,
	input  wire logic               soft_gate,
	input  wire logic               input_disable,
	input  wire logic               out_enable,
	input  wire logic [COUNT_W-1:0] upper_value,
	input  wire logic [COUNT_W-1:0] lower_value,
	output logic      [3:0]         status,
	output csw_pkg::csw_cmp_t       cmp_out,
	output logic      [COUNT_W-1:0] count
);

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	csw_pkg::csw_pins_t sync1_reg, sync2_reg, sync1_next, sync2_next;
	logic               pulse_d_reg, pulse_d_next;
	logic [COUNT_W-1:0] count_reg, count_next;
	logic [3:0]         status_reg, status_next;
	csw_pkg::csw_cmp_t  cmp_reg, cmp_next;
	logic               gate_on;
	logic               pulse_rise;

	always_comb begin
		sync1_next   = pins;
		sync2_next   = sync1_reg;
		pulse_d_next = sync2_reg.pulse;
		gate_on      = sync2_reg.gate & soft_gate;
		// Only the rising edge counts, so a long pulse is counted once.
		pulse_rise   = sync2_reg.pulse & ~pulse_d_reg;
		count_next   = count_reg;
		// Input-disable blocks pulses but leaves the gate running.
		if (gate_on && !input_disable && pulse_rise) begin
			count_next = count_reg + csw_pkg::COUNT_ONE;
		end
		status_next = '0;
		status_next[csw_pkg::STS_GATE_BIT]  = gate_on;
		status_next[csw_pkg::STS_LIMIT_BIT] = sync2_reg.limit;
		status_next[csw_pkg::STS_LOWER_BIT] = count_reg < lower_value;
		status_next[csw_pkg::STS_UPPER_BIT] = count_reg > upper_value;
		cmp_next.upper = out_enable & (count_reg > upper_value);
		cmp_next.lower = out_enable & (count_reg < lower_value);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			sync1_reg   <= '0;
			sync2_reg   <= '0;
			pulse_d_reg <= 1'b0;
			count_reg   <= csw_pkg::COUNT_ZERO;
			status_reg  <= '0;
			cmp_reg     <= '0;
		end else begin
			sync1_reg   <= sync1_next;
			sync2_reg   <= sync2_next;
			pulse_d_reg <= pulse_d_next;
			count_reg   <= count_next;
			status_reg  <= status_next;
			cmp_reg     <= cmp_next;
		end
	end

	assign status  = status_reg;
	assign cmp_out = cmp_reg;
	assign count   = count_reg;

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_disabled_no_count: assert property (
		@(posedge core_clk) disable iff (srst)
		input_disable |=> count_reg == $past(count_reg))
		else $error("count moved while input disabled");
	a_outputs_off: assert property (
		@(posedge core_clk) disable iff (srst)
		!out_enable |=> !cmp_reg.upper && !cmp_reg.lower)
		else $error("compare output on while disabled");
	a_no_gate_hold: assert property (
		@(posedge core_clk) disable iff (srst)
		!soft_gate |=> count_reg == $past(count_reg))
		else $error("count moved with soft gate off");
	// The first edge after reset still shows the cleared status.
	a_upper_flag: assert property (
		@(posedge core_clk) disable iff (srst)
		$past(srst) || status_reg[csw_pkg::STS_UPPER_BIT] ==
		($past(count_reg) > $past(upper_value)))
		else $error("upper status wrong");
	a_lower_flag: assert property (
		@(posedge core_clk) disable iff (srst)
		$past(srst) || status_reg[csw_pkg::STS_LOWER_BIT] ==
		($past(count_reg) < $past(lower_value)))
		else $error("lower status wrong");
	a_limit_flag: assert property (
		@(posedge core_clk) disable iff (srst)
		pins.limit ##3 1 |->
		status_reg[csw_pkg::STS_LIMIT_BIT] || $past(srst, 3))
		else $error("limit status late");
	a_gate_flag: assert property (
		@(posedge core_clk) disable iff (srst)
		$past(srst) || status_reg[csw_pkg::STS_GATE_BIT] ==
		($past(sync2_reg.gate) && $past(soft_gate)))
		else $error("gate status wrong");
	a_upper_pin: assert property (
		@(posedge core_clk) disable iff (srst)
		cmp_reg.upper ==
		($past(out_enable) && status_reg[csw_pkg::STS_UPPER_BIT]))
		else $error("upper pin disagrees with upper status");
	a_lower_pin: assert property (
		@(posedge core_clk) disable iff (srst)
		cmp_reg.lower ==
		($past(out_enable) && status_reg[csw_pkg::STS_LOWER_BIT]))
		else $error("lower pin disagrees with lower status");
	a_count_step: assert property (
		@(posedge core_clk) disable iff (srst)
		$past(srst) || $stable(count_reg) ||
		count_reg == $past(count_reg) + csw_pkg::COUNT_ONE)
		else $error("count moved by other than one");

endmodule : csw_channel

// >>> logic/csw_top.sv
`timescale 1ns/1ps

// Summary of operation
// - One 16-bit status word is read and one 16-bit command word written.
// - Status bits 3 and 7 show external gate and soft gate both on.
// - Status bits 2 and 6 follow the external limit input.
// - Status bits 1 and 5 show count below the lower compare value.
// - Status bits 0 and 4 show count above the upper compare value.
// - Status bits 15 to 8 have no meaning; here they read zero.
// - Command bits 3 and 7 block the count input of their channel.
// - Command bits 2 and 6 enable that channel's compare pins, else off.
// - Command bits 0 and 4 are soft gates; counting runs only while set.
// - Each channel has an upper and a lower compare pin of its own.
// - Upper pin on above the upper value, lower pin on below the lower.
// - Each counter is 24-bit unsigned binary.
module csw_top #(
	parameter int COUNT_W = csw_pkg::COUNT_W
) (
	input  wire logic                    core_clk,
	input  wire logic                    srst,
	input  wire logic [15:0]             command_output_word,
	input  wire logic                    command_write,
	output logic      [15:0]             status_input_word,
	input  csw_pkg::csw_pins_t [1:0]     ch_pins,
	input  wire logic [1:0][COUNT_W-1:0] upper_value,
	input  wire logic [1:0][COUNT_W-1:0] lower_value,
	output logic      [1:0][COUNT_W-1:0] count_value,
	output logic                         ch1_upper_compare_out,
	output logic                         ch1_lower_compare_out,
	output logic                         ch2_upper_compare_out,
	output logic                         ch2_lower_compare_out
);

	// ****************************************************************
	// Command word
	// ****************************************************************
	logic [15:0] cmd_reg, cmd_next;
	logic [1:0][3:0] ch_status;
	csw_pkg::csw_cmp_t [1:0] ch_cmp;

	always_comb begin
		cmd_next = cmd_reg;
		if (command_write) begin
			cmd_next = command_output_word;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			cmd_reg <= csw_pkg::CMD_RESET;
		end else begin
			cmd_reg <= cmd_next;
		end
	end

	// ****************************************************************
	// Channels
	// ****************************************************************
	// Unused command bits are stored but never steer anything.
	for (genvar c = 0; c < csw_pkg::NUM_CH; c++) begin : g_ch
		csw_channel #(
			.COUNT_W (COUNT_W)
		) u_ch (
			.core_clk      (core_clk),
			.srst          (srst),
			.pins          (ch_pins[c]),
			.soft_gate     (cmd_reg[c*4 + csw_pkg::CMD_SGATE_BIT]),
			.input_disable (cmd_reg[c*4 + csw_pkg::CMD_INDIS_BIT]),
			.out_enable    (cmd_reg[c*4 + csw_pkg::CMD_OEN_BIT]),
			.upper_value   (upper_value[c]),
			.lower_value   (lower_value[c]),
			.status        (ch_status[c]),
			.cmp_out       (ch_cmp[c]),
			.count         (count_value[c])
		);
	end

	assign status_input_word = {8'h00, ch_status[1], ch_status[0]};
	assign ch1_upper_compare_out = ch_cmp[0].upper;
	assign ch1_lower_compare_out = ch_cmp[0].lower;
	assign ch2_upper_compare_out = ch_cmp[1].upper;
	assign ch2_lower_compare_out = ch_cmp[1].lower;

	a_cmd_store: assert property (
		@(posedge core_clk) disable iff (srst)
		command_write |=> cmd_reg == $past(command_output_word))
		else $error("command word not stored");
	a_high_zero: assert property (
		@(posedge core_clk) disable iff (srst)
		status_input_word[15:8] == 8'h00)
		else $error("status high byte not zero");

endmodule : csw_top

// >>> test/csw_pulse_gen.sv
`timescale 1ns/1ps

// ****************************************************************
// Count pulse source.
// ****************************************************************
module csw_pulse_gen (
	input  wire logic core_clk,
	input  wire logic fire,
	output logic      pulse
);
	logic [2:0] width_reg = 3'h0;

	// Four cycles high keeps each pulse wide enough for the input stages.
	always_ff @(posedge core_clk) begin
		if (fire)
			width_reg <= 3'h4;
		else if (width_reg != 3'h0)
			width_reg <= width_reg - 3'h1;
	end
	assign pulse = (width_reg != 3'h0);
endmodule : csw_pulse_gen

// >>> test/tb.sv
`timescale 1ns/1ps

// ****************************************************************
// Bench.
// ****************************************************************
module tb;
	logic                     core_clk     = 1'b0;
	logic                     srst         = 1'b1;
	logic [15:0]              cmd          = 16'h0000;
	logic                     cmd_wr       = 1'b0;
	logic [15:0]              sts;
	logic [1:0]               gate         = 2'h0;
	logic [1:0]               limit        = 2'h0;
	logic [1:0]               fire         = 2'h0;
	logic [1:0]               pulse;
	logic [1:0][23:0]         count;
	logic [3:0]               outs;
	csw_pkg::csw_pins_t [1:0] pins;
	logic [1:0][23:0]         upv          = {24'h00_0005, 24'h00_0005};
	logic [1:0][23:0]         lov          = {24'h00_0002, 24'h00_0002};
	int                       errors       = 0;
	int                       total_checks = 0;

	assign pins[0] = {gate[0], limit[0], pulse[0]};
	assign pins[1] = {gate[1], limit[1], pulse[1]};
	csw_pulse_gen i_csw_pulse_gen_0 (.core_clk(core_clk), .fire(fire[0]),
		.pulse(pulse[0]));
	csw_pulse_gen i_csw_pulse_gen_1 (.core_clk(core_clk), .fire(fire[1]),
		.pulse(pulse[1]));
	csw_top i_csw_top (
		.core_clk              (core_clk),
		.srst                  (srst),
		.command_output_word   (cmd),
		.command_write         (cmd_wr),
		.status_input_word     (sts),
		.ch_pins               (pins),
		.upper_value           (upv),
		.lower_value           (lov),
		.count_value           (count),
		.ch1_upper_compare_out (outs[1]),
		.ch1_lower_compare_out (outs[0]),
		.ch2_upper_compare_out (outs[3]),
		.ch2_lower_compare_out (outs[2])
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
	endtask : step

	task automatic wr(input logic [15:0] w);
		@(posedge core_clk);
		cmd    <= w; // Unused bits always go out as zero.
		cmd_wr <= 1'b1;
		@(posedge core_clk);
		cmd_wr <= 1'b0;
		step(6);
	endtask : wr

	task automatic pulses(input int c, input int n);
		repeat (n) begin
			@(posedge core_clk);
			fire[c] <= 1'b1;
			@(posedge core_clk);
			fire[c] <= 1'b0;
			step(10);
		end
	endtask : pulses

	task automatic chk(input int c, input logic [3:0] nib, input logic [1:0] ul);
		logic [15:0] e;
		e = (c == 0) ? {8'h00, 4'h2, nib} : {8'h00, nib, 4'h1};
		check({sts, outs}, {e, 4'(ul) << (2 * c)});
	endtask : chk

	task automatic complete_run;
		if (errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	initial begin
		forever #2.5 core_clk = ~core_clk;
	end

	initial begin
		step(20);
		check({sts, outs}, 32'h0000_0000);
		srst <= 1'b0;
		for (int c = 0; c < 2; c++) begin
			wr(16'h0000);
			chk(c, 4'h2, 2'h0);
			wr(16'h0004 << (4 * c));
			chk(c, 4'h2, 2'h1);
			gate[c]  <= 1'b1;
			limit[c] <= 1'b1;
			step(6);
			chk(c, 4'h6, 2'h1);
			wr(16'h0005 << (4 * c));
			chk(c, 4'he, 2'h1);
			pulses(c, 3);
			check(count[c], 32'h0000_0003);
			chk(c, 4'hc, 2'h0);
			wr(16'h000d << (4 * c));
			pulses(c, 2);
			check(count[c], 32'h0000_0003);
			wr(16'h0005 << (4 * c));
			pulses(c, 3);
			chk(c, 4'hd, 2'h2);
			upv[c] <= 24'h00_0006;
			lov[c] <= 24'h00_0006;
			step(2);
			chk(c, 4'hc, 2'h0);
			upv[c] <= 24'h00_0005;
			lov[c] <= 24'h00_0002;
			wr(16'h0004 << (4 * c));
			pulses(c, 1);
			check(count[c], 32'h0000_0006);
			chk(c, 4'h5, 2'h2);
			gate[c]  <= 1'b0;
			limit[c] <= 1'b0;
			wr(16'h0005 << (4 * c));
			pulses(c, 1);
			check(count[c], 32'h0000_0006);
			chk(c, 4'h1, 2'h2);
			wr(16'h0000);
			chk(c, 4'h1, 2'h0);
		end
		complete_run();
	end
endmodule : tb
